// ==== design/cis_top.sv ====
/*
  interrupt detection, acknowledge and status pins of the cpu.
  assumes pins are asynchronous to ref_clk and the cpu core grants service.
*/
`timescale 1ns/1ps
`include "cis_regs.svh"
module cis_top (
  input wire logic ref_clk, // cpu clock, 100 mhz
  input wire logic srst, // synchronous reset, active high
  input wire logic nmi_pin, // nonmaskable interrupt pin
  input wire logic [`CIS_NUM_EXT-1:0] ext_irq_line, // ext_irq_line_7..4 as [3:0]
  input wire logic service_grant, // core takes highest pending interrupt
  input wire logic byte_order_select, // high = little endian
  input wire logic [1:0] pd_mode, // core power-down mode
  output logic little_endian, // synchronised byte order
  output logic [4:0] pending, // pending requests, bit 0 = nmi
  output logic irq_serviced_strobe, // one-cycle acknowledge
  output logic active_irq_id_bit3, // id bit 3
  output logic active_irq_id_bit2, // id bit 2
  output logic active_irq_id_bit1, // id bit 1
  output logic active_irq_id_bit0, // id bit 0
  output logic powerdown_status_out // high in mode 2 or 3
);
  logic [5:0] sync1_r; // first synchroniser stage, bit 5 = byte order
  logic [5:0] sync2_r; // second synchroniser stage
  logic [4:0] prev_r; // last seen request levels, for edge detection
  logic [4:0] pend_r, rise, clr;
  cis_pkg::cis_ack_t ack_r, ack_nxt;
  cis_pkg::cis_state_t st_r, st_nxt;
  logic pd_r;

  // pick highest priority pending: nmi, then ext4 upward
  function automatic logic [4:0] pick(input logic [4:0] p);
    logic [4:0] m;
    m = 5'h00;
    for (int i = 4; i >= 0; i--) begin
      if (p[i]) begin
        m = 5'h01 << i;
      end
    end
    return m;
  endfunction

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    sync1_r <= {byte_order_select, ext_irq_line, nmi_pin};
    sync2_r <= sync1_r;
    prev_r <= srst ? `CIS_PEND_RST : sync2_r[4:0]; // low matches the idle pins
  end

  // edge detect and priority pick; grants are ignored while an acknowledge is out
  assign rise = sync2_r[4:0] & ~prev_r;
  assign clr = (service_grant && st_r == cis_pkg::CIS_IDLE) ? pick(pend_r) : `CIS_PEND_RST;

  // pending latch; a new edge wins over the clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_r <= `CIS_PEND_RST;
    end else begin
      pend_r <= (pend_r & ~clr) | rise;
    end
  end

  // id by service table position: nmi slot, then ext slots 4..7
  always_comb begin
    ack_nxt = '0;
    if (clr != 5'h00) begin
      ack_nxt.strobe = 1'b1;
      ack_nxt.id = clr[0] ? `CIS_NMI_ID : `CIS_EXT4_ID;
      for (int i = 1; i < 5; i++) begin
        if (clr[i]) begin
          ack_nxt.id = `CIS_EXT4_ID + 4'(i - 1);
        end
      end
    end
  end

  // acknowledge register; id held with strobe so it is valid throughout
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_r <= '0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // servicing state; one quiet cycle after each acknowledge keeps strobes apart
  always_comb begin
    st_nxt = cis_pkg::CIS_IDLE;
    case (st_r)
      cis_pkg::CIS_IDLE: begin
        st_nxt = ack_nxt.strobe ? cis_pkg::CIS_ACK : cis_pkg::CIS_IDLE;
      end
      cis_pkg::CIS_ACK: begin
        st_nxt = cis_pkg::CIS_IDLE; // a grant in this cycle is ignored
      end
      default: begin
        st_nxt = cis_pkg::CIS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= cis_pkg::CIS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // power-down status flop
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= (pd_mode == `CIS_PD_MODE2) || (pd_mode == `CIS_PD_MODE3);
    end
  end

  // outputs; id and strobe come straight from the acknowledge flops
  assign little_endian = sync2_r[5];
  assign pending = pend_r;
  assign irq_serviced_strobe = ack_r.strobe;
  assign {active_irq_id_bit3, active_irq_id_bit2, active_irq_id_bit1,
          active_irq_id_bit0} = ack_r.id;
  assign powerdown_status_out = pd_r;

  // a rising nmi line always leaves a pending request
  property p_rise_pends;
    @(posedge ref_clk) disable iff (srst)
      rise[0] |=> pend_r[0];
  endproperty
  a_rise_pends: assert property (p_rise_pends) else $error("nmi edge not pending");

  // the same for the last external line
  property p_ext_pends;
    @(posedge ref_clk) disable iff (srst)
      rise[4] |=> pend_r[4];
  endproperty
  a_ext_pends: assert property (p_ext_pends) else $error("ext7 edge lost");

  // a line that only stays high never makes a new request
  property p_no_level;
    @(posedge ref_clk) disable iff (srst)
      (rise == '0) && (pend_r == '0) |=> (pend_r == '0);
  endproperty
  a_no_level: assert property (p_no_level) else $error("request without edge");

  // the acknowledge is a single-cycle pulse
  property p_ack_one;
    @(posedge ref_clk) disable iff (srst)
      irq_serviced_strobe |=> !irq_serviced_strobe;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a pulse");

  // every taken grant is acknowledged on the next cycle
  property p_ack_follows;
    @(posedge ref_clk) disable iff (srst)
      (clr != '0) |=> irq_serviced_strobe;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("grant without ack");

  // no acknowledge appears without a taken grant
  property p_no_stray;
    @(posedge ref_clk) disable iff (srst)
      (clr == '0) |=> !irq_serviced_strobe;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("ack without grant");

  // a grant in the same cycle as an acknowledge is ignored
  property p_refuse;
    @(posedge ref_clk) disable iff (srst)
      (st_r == cis_pkg::CIS_ACK) |-> (clr == '0);
  endproperty
  a_refuse: assert property (p_refuse) else $error("grant taken while busy");

  // nmi shows its own id while the strobe stands
  property p_nmi_id;
    @(posedge ref_clk) disable iff (srst)
      clr[0] |=> irq_serviced_strobe && (ack_r.id == `CIS_NMI_ID);
  endproperty
  a_nmi_id: assert property (p_nmi_id) else $error("nmi id wrong");

  // the id lines rest at zero between acknowledges
  property p_id_idle;
    @(posedge ref_clk) disable iff (srst)
      !irq_serviced_strobe |-> (ack_r.id == '0);
  endproperty
  a_id_idle: assert property (p_id_idle) else $error("id shown without ack");

  // first external slot of the service table
  property p_ext4_id;
    @(posedge ref_clk) disable iff (srst)
      clr[1] |=> (ack_r.id == `CIS_EXT4_ID);
  endproperty
  a_ext4_id: assert property (p_ext4_id) else $error("ext4 id wrong");

  // last external slot of the service table
  property p_ext7_id;
    @(posedge ref_clk) disable iff (srst)
      clr[4] |=> (ack_r.id == `CIS_EXT7_ID);
  endproperty
  a_ext7_id: assert property (p_ext7_id) else $error("ext7 id wrong");

  // power-down status shown in the two deep modes
  property p_pd;
    @(posedge ref_clk) disable iff (srst)
      pd_mode[1] |=> powerdown_status_out;
  endproperty
  a_pd: assert property (p_pd) else $error("pd not shown");

  // and low in the shallow ones
  property p_pd_off;
    @(posedge ref_clk) disable iff (srst)
      !pd_mode[1] |=> !powerdown_status_out;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("pd false");

  // a pending request survives until it is served
  property p_hold;
    @(posedge ref_clk) disable iff (srst)
      pend_r[1] && !clr[1] |=> pend_r[1];
  endproperty
  a_hold: assert property (p_hold) else $error("pending lost");

  // a served request is dropped unless a new edge lands in the same cycle
  property p_nmi_clear;
    @(posedge ref_clk) disable iff (srst)
      clr[0] && !rise[0] |=> !pend_r[0];
  endproperty
  a_nmi_clear: assert property (p_nmi_clear) else $error("served nmi still pending");

  // main scenarios reached
  c_nmi: cover property (@(posedge ref_clk) clr[0]);
  c_ext: cover property (@(posedge ref_clk) clr[4]);
  c_pd: cover property (@(posedge ref_clk) powerdown_status_out);
  c_busy: cover property (@(posedge ref_clk) service_grant && st_r == cis_pkg::CIS_ACK);
endmodule

// ==== design/cis_regs.svh ====
/*
  constants for the cpu interrupt and status pin block.
  assumes it is included by bare name from the module; the package does not include it.
*/
// What this block does
// - nmi and external irqs detected on rising edge
// - pulse acknowledge when cpu services an interrupt
// - id outputs valid while acknowledge is high
// - id encodes service table position
// - byte order select high means little endian
// - powerdown status high in mode 2 or 3
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH
`define CIS_NMI_ID 4'h1
`define CIS_EXT4_ID 4'h4
`define CIS_EXT7_ID 4'h7
`define CIS_PEND_RST 5'h00
`define CIS_PD_MODE2 2'h2
`define CIS_PD_MODE3 2'h3
`define CIS_NUM_EXT 4
`endif

// ==== design/cis_pkg.sv ====
/*
  types for the cpu interrupt and status pin block.
  assumes cis_regs.svh is on the include path.
*/
package cis_pkg;
  // interrupt id and acknowledge travel together
  typedef struct packed {
    logic strobe;
    logic [3:0] id;
  } cis_ack_t;
  // servicing state
  typedef enum logic [1:0] {
    CIS_IDLE = 2'h0,
    CIS_ACK = 2'h1
  } cis_state_t;
endpackage

// ==== tb/cis_board.sv ====
/* board-side model driving the interrupt lines.
  assumes the bench sets req between clock edges. */
`timescale 1ns/1ps
module cis_board (
  input wire logic ref_clk, // cpu clock
  input wire logic [4:0] req, // wanted levels, bit 0 = nmi
  output logic nmi_pin = 1'b0, // nonmaskable line
  output logic [3:0] ext_irq_line = 4'h0 // external lines
);
  // registered so the lines change only on the rising edge of ref_clk, the same edge at which the design samples them
  always @(posedge ref_clk) begin
    {ext_irq_line, nmi_pin} <= req;
  end
endmodule

// ==== tb/cis_tb.sv ====
/* self-checking bench for the interrupt and status pins.
  assumes cis_top and cis_board are compiled first. */
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, srst = 1'b1, gr = 1'b0, bos = 1'b0;
  logic [1:0] pd = 2'h0;
  logic [4:0] req = 5'h00;
  wire nmi, le, stb, pdo;
  wire [3:0] ext, id;
  wire [4:0] pend;
  int bad_count = 0, checked = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  cis_board board (.ref_clk(ref_clk), .req(req), .nmi_pin(nmi), .ext_irq_line(ext));
  cis_top dut (.ref_clk(ref_clk), .srst(srst), .nmi_pin(nmi), .ext_irq_line(ext),
    .service_grant(gr), .byte_order_select(bos), .pd_mode(pd), .little_endian(le),
    .pending(pend), .irq_serviced_strobe(stb), .active_irq_id_bit3(id[3]),
    .active_irq_id_bit2(id[2]), .active_irq_id_bit1(id[1]), .active_irq_id_bit0(id[0]),
    .powerdown_status_out(pdo));
  task chk(input string n, input logic [4:0] e, input logic [4:0] s);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang costs a mismatch and still reaches the report
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 400) begin
      bad_count++;
      wrap_up;
    end
  end
  // all five rise together; served by priority, one grant every other cycle
  task t_prio;
    req = 5'h1f;
    repeat (4) @(negedge ref_clk);
    chk("pending", 5'h1f, pend);
    for (int i = 0; i < 5; i++) begin
      gr = 1'b1;
      @(negedge ref_clk);
      gr = 1'b0;
      chk("strobe", 5'h01, {4'h0, stb});
      chk("id", (i == 0) ? 5'h01 : 5'(i + 3), {1'b0, id});
      chk("served", 5'(5'h1f << (i + 1)), pend);
      @(negedge ref_clk);
    end
    gr = 1'b1;
    @(negedge ref_clk);
    gr = 1'b0;
    chk("idle grant", 5'h00, {stb, id});
    chk("held high", 5'h00, pend);
    req = 5'h00;
  endtask
  task t_order;
    bos = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("little", 5'h01, {4'h0, le});
    bos = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("big", 5'h00, {4'h0, le});
  endtask
  task t_pd;
    for (int m = 0; m < 4; m++) begin
      pd = m[1:0];
      @(negedge ref_clk);
      chk("pd", {4'h0, m >= 2}, {4'h0, pdo});
    end
  endtask
  // reset in mid-run drops pending work; after release a fresh edge is served
  task t_reset;
    req = 5'h02;
    repeat (4) @(negedge ref_clk);
    chk("ext4 pending", 5'h02, pend);
    srst = 1'b1;
    req = 5'h00;
    repeat (3) @(negedge ref_clk);
    chk("reset drops", 5'h00, pend);
    chk("reset ack", 5'h00, {stb, id});
    srst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("no false edge", 5'h00, pend);
    req = 5'h02;
    repeat (4) @(negedge ref_clk);
    gr = 1'b1;
    @(negedge ref_clk);
    gr = 1'b0;
    chk("ext4 served", 5'h14, {stb, id});
    req = 5'h00;
    @(negedge ref_clk);
  endtask
  // new edge in the serving cycle stays pending; the grant right after is ignored
  task t_set_wins;
    req = 5'h01;
    repeat (4) @(negedge ref_clk);
    chk("nmi pending", 5'h01, pend);
    req = 5'h00;
    repeat (2) @(negedge ref_clk);
    req = 5'h01;
    repeat (3) @(negedge ref_clk);
    gr = 1'b1;
    @(negedge ref_clk);
    chk("served nmi", 5'h11, {stb, id});
    chk("edge kept", 5'h01, pend);
    @(negedge ref_clk);
    chk("busy grant", 5'h00, {stb, id});
    chk("still kept", 5'h01, pend);
    @(negedge ref_clk);
    chk("served again", 5'h11, {stb, id});
    chk("cleared", 5'h00, pend);
    gr = 1'b0;
    req = 5'h00;
    @(negedge ref_clk);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    chk("reset", 5'h00, {stb, id});
    srst = 1'b0;
    t_prio;
    t_order;
    t_pd;
    t_reset;
    t_set_wins;
    wrap_up;
  end
endmodule
